// ### fpmc_err_slot.sv
// One self-test error flag with a single retry
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module fpmc_err_slot (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Check results
  input wire logic fail_pulse,
  input wire logic pass_pulse,
  // State
  output logic err_r,
  output logic retry_req_r
);
  logic err_nxt;
  logic retry_req_nxt;
  logic [1:0] tries_r;
  logic [1:0] tries_nxt;

  always_comb begin
    err_nxt = err_r;
    retry_req_nxt = 1'b0;
    tries_nxt = tries_r;
    if (fail_pulse) begin
      err_nxt = 1'b1;
      // Only a limited number of retries; a persistent fault stays shown
      if (tries_r < `FPMC_RETRY_MAX) begin
        retry_req_nxt = 1'b1;
        tries_nxt = tries_r + 2'h1;
      end
    end else if (pass_pulse) begin
      err_nxt = 1'b0;
      tries_nxt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      err_r <= 1'b0;
      retry_req_r <= 1'b0;
      tries_r <= 2'h0;
    end else begin
      err_r <= err_nxt;
      retry_req_r <= retry_req_nxt;
      tries_r <= tries_nxt;
    end
  end
endmodule

// ### fpmc_panel_model.sv
// Keypad operator and remote bus controller model for the front-panel mode control block
`timescale 1ns/1ns
module fpmc_panel_model (
  // Clock
  input wire logic sys_clk,
  // Keypad
  output logic key_valid,
  output logic [3:0] key_code,
  output logic [3:0] key_digit,
  // Remote controller events
  output logic remote_cmd,
  output logic remote_lockout,
  output logic remote_unlock
);
  initial begin
    key_valid = 1'b0;
    key_code = 4'hF;
    key_digit = 4'hF;
    remote_cmd = 1'b0;
    remote_lockout = 1'b0;
    remote_unlock = 1'b0;
  end
  // Idle code lines carry the inverse of the last press, so a stale code never matches the code just pressed
  task automatic press(input logic [3:0] code, input logic [3:0] digit);
    @(negedge sys_clk);
    key_valid = 1'b1;
    key_code = code;
    key_digit = digit;
    @(negedge sys_clk);
    key_valid = 1'b0;
    key_code = ~code;
    key_digit = ~digit;
  endtask
  // Kind 0 plain command, 1 keypad lockout, 2 keypad unlock
  task automatic remote(input logic [1:0] kind);
    @(negedge sys_clk);
    remote_cmd = (kind == 2'h0);
    remote_lockout = (kind == 2'h1);
    remote_unlock = (kind == 2'h2);
    @(negedge sys_clk);
    remote_cmd = 1'b0;
    remote_lockout = 1'b0;
    remote_unlock = 1'b0;
  endtask
endmodule

// ### fpmc_pkg.sv
// Types for the front-panel mode control block
package fpmc_pkg;
  typedef enum logic [2:0] {
    FPMC_MENU_NONE = 3'b001,
    FPMC_MENU_CONTRAST = 3'b010,
    FPMC_MENU_SPEAKER = 3'b100
  } fpmc_menu_t;
endpackage

// ### fpmc_regs.svh
// Constants for the front-panel mode control block
`ifndef FPMC_REGS_SVH
`define FPMC_REGS_SVH
`define FPMC_CONTRAST_MAX 4'h9
`define FPMC_CONTRAST_RST 4'h5
`define FPMC_SPEAKER_RST 1'b1
`define FPMC_KEY_W 4
`define FPMC_KEY_NONE 4'h0
`define FPMC_KEY_LOCAL 4'h1
`define FPMC_KEY_OUTPUT 4'h2
`define FPMC_KEY_MENU 4'h3
`define FPMC_KEY_UP 4'h4
`define FPMC_KEY_DOWN 4'h5
`define FPMC_KEY_ENTER 4'h6
`define FPMC_KEY_CLEAR 4'h7
`define FPMC_KEY_DIGIT 4'h8
`define FPMC_ERR_PROGMEM 3'h0
`define FPMC_ERR_WORKMEM 3'h1
`define FPMC_ERR_NVSTAT 3'h2
`define FPMC_ERR_PAGE 3'h3
`define FPMC_ERR_CONFIG 3'h4
`define FPMC_ERR_NUM 5
`define FPMC_RETRY_MAX 2'h1
`endif

// ### fpmc_top.sv
// Front-panel mode, lockout, display settings and output enable control
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module fpmc_top
  import fpmc_pkg::*;
#(
  parameter int ERR_NUM = `FPMC_ERR_NUM
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Front keypad, one-cycle key strobe with code and digit value
  input wire logic key_valid,
  input wire logic [3:0] key_code,
  input wire logic [3:0] key_digit,
  // Remote bus controller events, one-cycle pulses
  input wire logic remote_cmd,
  input wire logic remote_lockout,
  input wire logic remote_unlock,
  // Stored settings and measured state
  input wire logic pwrup_out_on,
  input wire logic cc_active,
  // Beep requests
  input wire logic beep_normal,
  input wire logic beep_safety,
  // Self-test results per check, one-cycle pulses
  input wire logic [ERR_NUM-1:0] test_fail,
  input wire logic [ERR_NUM-1:0] test_pass,
  // Mode and indicators
  output logic remote_mode_r,
  output logic remote_indicator_r,
  output logic local_indicator_r,
  output logic lockout_indicator_r,
  output logic keys_accepted_r,
  // Display settings
  output logic [3:0] contrast_r,
  output logic speaker_en_r,
  output logic beep_r,
  // Output control
  output logic output_on_r,
  output logic program_zero_r,
  output logic off_indication_r,
  output logic show_measured_r,
  output logic constant_voltage_regulation_r,
  output logic constant_current_regulation_r,
  output logic command_entry_r,
  // Self-test
  output logic [ERR_NUM-1:0] error_flags,
  output logic [ERR_NUM-1:0] retry_req
);
  logic lockout_r, lockout_nxt;
  logic remote_nxt;
  logic [3:0] contrast_nxt;
  logic speaker_nxt;
  logic out_nxt;
  logic init_r;
  fpmc_menu_t menu_r, menu_nxt;
  logic key_ok;

  // Remote mode masks every key except local
  assign key_ok = key_valid && (!remote_mode_r || key_code == `FPMC_KEY_LOCAL);

  always_comb begin
    remote_nxt = remote_mode_r;
    lockout_nxt = lockout_r;
    if (remote_lockout) begin
      lockout_nxt = 1'b1;
    end
    if (remote_unlock) begin
      lockout_nxt = 1'b0;
    end
    if (remote_cmd || remote_lockout || remote_unlock) begin
      remote_nxt = 1'b1;
    end else if (key_ok && key_code == `FPMC_KEY_LOCAL && !lockout_r) begin
      remote_nxt = 1'b0;
    end
  end

  always_comb begin
    menu_nxt = menu_r;
    contrast_nxt = contrast_r;
    speaker_nxt = speaker_en_r;
    if (key_ok && !remote_mode_r) begin
      unique case (menu_r)
        FPMC_MENU_NONE: begin
          if (key_code == `FPMC_KEY_MENU) begin
            menu_nxt = FPMC_MENU_CONTRAST;
          end
        end
        FPMC_MENU_CONTRAST: begin
          if (key_code == `FPMC_KEY_UP && contrast_r < `FPMC_CONTRAST_MAX) begin
            contrast_nxt = contrast_r + 4'h1;
          end else if (key_code == `FPMC_KEY_DOWN && contrast_r != 4'h0) begin
            contrast_nxt = contrast_r - 4'h1;
          end else if (key_code == `FPMC_KEY_DIGIT && key_digit <= `FPMC_CONTRAST_MAX) begin
            contrast_nxt = key_digit;
          end else if (key_code == `FPMC_KEY_MENU) begin
            menu_nxt = FPMC_MENU_SPEAKER;
          end else if (key_code == `FPMC_KEY_ENTER || key_code == `FPMC_KEY_CLEAR) begin
            menu_nxt = FPMC_MENU_NONE;
          end
        end
        FPMC_MENU_SPEAKER: begin
          if (key_code == `FPMC_KEY_DIGIT && key_digit == 4'h1) begin
            speaker_nxt = 1'b1;
          end else if (key_code == `FPMC_KEY_DIGIT && key_digit == 4'h0) begin
            speaker_nxt = 1'b0;
          end else if (key_code == `FPMC_KEY_MENU || key_code == `FPMC_KEY_ENTER ||
                       key_code == `FPMC_KEY_CLEAR) begin
            menu_nxt = FPMC_MENU_NONE;
          end
        end
        default: menu_nxt = FPMC_MENU_NONE;
      endcase
    end
  end

  always_comb begin
    out_nxt = output_on_r;
    // Power-up selection is sampled on the first clock after release
    if (init_r) begin
      out_nxt = pwrup_out_on;
    end else if (key_ok && !remote_mode_r && menu_r == FPMC_MENU_NONE && key_code == `FPMC_KEY_OUTPUT) begin
      out_nxt = !output_on_r;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_r <= 1'b1;
      remote_mode_r <= 1'b0;
      lockout_r <= 1'b0;
      menu_r <= FPMC_MENU_NONE;
      contrast_r <= `FPMC_CONTRAST_RST;
      speaker_en_r <= `FPMC_SPEAKER_RST;
      output_on_r <= 1'b0;
      remote_indicator_r <= 1'b0;
      local_indicator_r <= 1'b1;
      lockout_indicator_r <= 1'b0;
      keys_accepted_r <= 1'b1;
      beep_r <= 1'b0;
      program_zero_r <= 1'b1;
      off_indication_r <= 1'b1;
      show_measured_r <= 1'b1;
      constant_voltage_regulation_r <= 1'b0;
      constant_current_regulation_r <= 1'b0;
      command_entry_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
      remote_mode_r <= remote_nxt;
      lockout_r <= lockout_nxt;
      menu_r <= menu_nxt;
      contrast_r <= contrast_nxt;
      speaker_en_r <= speaker_nxt;
      output_on_r <= out_nxt;
      remote_indicator_r <= remote_nxt;
      local_indicator_r <= !lockout_nxt;
      lockout_indicator_r <= lockout_nxt;
      keys_accepted_r <= !remote_nxt;
      beep_r <= beep_safety || (beep_normal && speaker_nxt);
      program_zero_r <= !out_nxt;
      off_indication_r <= !out_nxt;
      show_measured_r <= 1'b1;
      constant_voltage_regulation_r <= out_nxt && !cc_active;
      constant_current_regulation_r <= out_nxt && cc_active;
      // Output key never leaves command entry; menus are a separate status
      command_entry_r <= menu_nxt == FPMC_MENU_NONE;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ERR_NUM; gi++) begin : g_err
      // One slot per check keeps each failure reported separately
      fpmc_err_slot u_slot (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .fail_pulse(test_fail[gi]),
        .pass_pulse(test_pass[gi]),
        .err_r(error_flags[gi]),
        .retry_req_r(retry_req[gi])
      );
    end
  endgenerate

  AST_LOCAL_BACK: assert property (@(posedge sys_clk) disable iff (!resetn)
    key_valid && key_code == `FPMC_KEY_LOCAL && !lockout_r && !remote_cmd && !remote_lockout && !remote_unlock
    |=> !remote_mode_r) else $error("local key did not restore local mode");
  AST_REMOTE_ENTRY: assert property (@(posedge sys_clk) disable iff (!resetn)
    remote_cmd |=> remote_mode_r && remote_indicator_r) else $error("remote command ignored");
  AST_LOCKOUT_HOLDS: assert property (@(posedge sys_clk) disable iff (!resetn)
    lockout_r && !remote_unlock |=> remote_mode_r == $past(remote_mode_r) || remote_mode_r)
    else $error("lockout let local key through");
  AST_LOCK_IND: assert property (@(posedge sys_clk) disable iff (!resetn)
    remote_lockout && !remote_unlock |=> lockout_indicator_r && !local_indicator_r)
    else $error("lockout indicator not shown");
  AST_UNLOCK_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
    lockout_r && !remote_unlock |=> lockout_r) else $error("lockout cleared without unlock");
  AST_REMOTE_KEYS: assert property (@(posedge sys_clk) disable iff (!resetn)
    remote_mode_r && key_valid && key_code == `FPMC_KEY_OUTPUT |=> $stable(output_on_r))
    else $error("key acted in remote mode");
  AST_CONTRAST_RANGE: assert property (@(posedge sys_clk) disable iff (!resetn)
    contrast_r <= `FPMC_CONTRAST_MAX) else $error("contrast out of range");
  AST_SAFETY_BEEP: assert property (@(posedge sys_clk) disable iff (!resetn)
    beep_safety |=> beep_r) else $error("safety beep muted");
  AST_OUT_OFF_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
    !init_r && output_on_r |-> !program_zero_r && !off_indication_r) else $error("off indication wrong");
  AST_ERR_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    test_pass[0] && !test_fail[0] |=> !error_flags[0]) else $error("pass did not clear error");

  COV_REMOTE: cover property (@(posedge sys_clk) disable iff (!resetn) remote_cmd ##1 remote_mode_r);
  COV_LOCKOUT: cover property (@(posedge sys_clk) disable iff (!resetn) lockout_indicator_r ##1 remote_unlock);
  COV_TOGGLE: cover property (@(posedge sys_clk) disable iff (!resetn) output_on_r ##1 !output_on_r);
  COV_RETRY: cover property (@(posedge sys_clk) disable iff (!resetn) retry_req[0]);
endmodule

// ### tb.sv
// Self-checking testbench for the front-panel mode control block
`timescale 1ns/1ns
`include "fpmc_regs.svh"
module tb;
  logic sys_clk, resetn, key_valid, remote_cmd, remote_lockout, remote_unlock;
  logic [3:0] key_code, key_digit, contrast_r;
  logic pwrup_out_on, cc_active, beep_normal, beep_safety;
  logic [4:0] test_fail, test_pass, error_flags, retry_req, m;
  logic remote_mode_r, remote_indicator_r, local_indicator_r, lockout_indicator_r, keys_accepted_r;
  logic speaker_en_r, beep_r, output_on_r, program_zero_r, off_indication_r, show_measured_r;
  logic cv_r, cc_r, command_entry_r;
  int miscompares = 0;
  int checks = 0;
  fpmc_top u_fpmc_top (.sys_clk(sys_clk), .resetn(resetn), .key_valid(key_valid), .key_code(key_code),
    .key_digit(key_digit), .remote_cmd(remote_cmd), .remote_lockout(remote_lockout),
    .remote_unlock(remote_unlock), .pwrup_out_on(pwrup_out_on), .cc_active(cc_active),
    .beep_normal(beep_normal), .beep_safety(beep_safety), .test_fail(test_fail), .test_pass(test_pass),
    .remote_mode_r(remote_mode_r), .remote_indicator_r(remote_indicator_r),
    .local_indicator_r(local_indicator_r), .lockout_indicator_r(lockout_indicator_r),
    .keys_accepted_r(keys_accepted_r), .contrast_r(contrast_r), .speaker_en_r(speaker_en_r),
    .beep_r(beep_r), .output_on_r(output_on_r), .program_zero_r(program_zero_r),
    .off_indication_r(off_indication_r), .show_measured_r(show_measured_r),
    .constant_voltage_regulation_r(cv_r), .constant_current_regulation_r(cc_r),
    .command_entry_r(command_entry_r), .error_flags(error_flags), .retry_req(retry_req));
  fpmc_panel_model u_fpmc_panel_model (.sys_clk(sys_clk), .key_valid(key_valid), .key_code(key_code),
    .key_digit(key_digit), .remote_cmd(remote_cmd), .remote_lockout(remote_lockout),
    .remote_unlock(remote_unlock));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic key(input logic [3:0] code, input logic [3:0] digit = 4'h0);
    u_fpmc_panel_model.press(code, digit);
  endtask
  // Run is under two hundred cycles; this 5000-cycle margin only catches a hang
  initial begin
    #(50 * 5000);
    miscompares++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    pwrup_out_on = 1'b1;
    cc_active = 1'b0;
    beep_normal = 1'b0;
    beep_safety = 1'b0;
    test_fail = 5'h00;
    test_pass = 5'h00;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("remote_mode", remote_mode_r, 8'h00);
    chk("local_ind", local_indicator_r, 8'h01);
    chk("contrast", contrast_r, 8'h05);
    chk("speaker", speaker_en_r, 8'h01);
    chk("output_on", output_on_r, 8'h01);
    chk("measured", show_measured_r, 8'h01);
    cc_active = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("cc", cc_r, 8'h01);
    cc_active = 1'b0;
    key(`FPMC_KEY_OUTPUT);
    chk("out_off", {output_on_r, program_zero_r, off_indication_r, command_entry_r}, 8'h07);
    key(`FPMC_KEY_OUTPUT);
    chk("out_on", {output_on_r, program_zero_r, off_indication_r, cv_r}, 8'h09);
    key(`FPMC_KEY_MENU);
    key(`FPMC_KEY_OUTPUT);
    chk("menu_out", {output_on_r, command_entry_r}, 8'h02);
    repeat (5) key(`FPMC_KEY_UP);
    chk("ctr_top", contrast_r, 8'h09);
    key(`FPMC_KEY_DOWN);
    chk("ctr_dn", contrast_r, 8'h08);
    key(`FPMC_KEY_DIGIT, 4'h0);
    key(`FPMC_KEY_DOWN);
    key(`FPMC_KEY_DIGIT, 4'hC);
    chk("ctr_low", contrast_r, 8'h00);
    key(`FPMC_KEY_DIGIT, 4'h9);
    chk("ctr_dig", contrast_r, 8'h09);
    key(`FPMC_KEY_MENU);
    key(`FPMC_KEY_DIGIT, 4'h0);
    chk("spk_off", speaker_en_r, 8'h00);
    beep_normal = 1'b1;
    @(negedge sys_clk);
    chk("beep_mute", beep_r, 8'h00);
    beep_safety = 1'b1;
    @(negedge sys_clk);
    chk("beep_safe", beep_r, 8'h01);
    beep_safety = 1'b0;
    key(`FPMC_KEY_DIGIT, 4'h1);
    chk("beep_on", {speaker_en_r, beep_r}, 8'h03);
    beep_normal = 1'b0;
    key(`FPMC_KEY_ENTER);
    chk("menu_exit", command_entry_r, 8'h01);
    key(`FPMC_KEY_MENU);
    key(`FPMC_KEY_CLEAR);
    chk("menu_clear", {command_entry_r, contrast_r}, 8'h19);
    repeat (3) key(`FPMC_KEY_MENU);
    chk("menu_wrap", {command_entry_r, speaker_en_r}, 8'h03);
    u_fpmc_panel_model.remote(2'h0);
    chk("remote", {remote_mode_r, remote_indicator_r, keys_accepted_r}, 8'h06);
    key(`FPMC_KEY_OUTPUT);
    key(`FPMC_KEY_MENU);
    chk("rem_keys", {output_on_r, command_entry_r}, 8'h03);
    key(`FPMC_KEY_LOCAL);
    chk("local", remote_mode_r, 8'h00);
    u_fpmc_panel_model.remote(2'h1);
    chk("lockout", {remote_mode_r, lockout_indicator_r, local_indicator_r}, 8'h06);
    key(`FPMC_KEY_LOCAL);
    u_fpmc_panel_model.remote(2'h0);
    chk("locked", {remote_mode_r, lockout_indicator_r}, 8'h03);
    u_fpmc_panel_model.remote(2'h2);
    chk("unlock", {lockout_indicator_r, local_indicator_r}, 8'h01);
    key(`FPMC_KEY_LOCAL);
    chk("unl_local", remote_mode_r, 8'h00);
    for (int i = 0; i < 5; i++) begin
      m = 5'h01 << i;
      @(negedge sys_clk) test_fail = m;
      @(negedge sys_clk) test_fail = 5'h00;
      chk("err", {error_flags, 3'h0}, {m, 3'h0});
      chk("retry", retry_req, m);
      @(negedge sys_clk) test_fail = m;
      @(negedge sys_clk) test_fail = 5'h00;
      chk("retry2", retry_req, 8'h00);
      @(negedge sys_clk) test_pass = m;
      @(negedge sys_clk) test_pass = 5'h00;
      chk("err_clr", error_flags, 8'h00);
    end
    @(negedge sys_clk);
    test_fail = 5'h01;
    test_pass = 5'h01;
    @(negedge sys_clk);
    test_fail = 5'h00;
    test_pass = 5'h00;
    chk("fail_wins", {error_flags, retry_req}, 8'h21);
    u_fpmc_panel_model.remote(2'h1);
    resetn = 1'b0;
    pwrup_out_on = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("pwr_cycle", {remote_mode_r, lockout_indicator_r, local_indicator_r}, 8'h01);
    chk("pwr_out", {output_on_r, off_indication_r, contrast_r}, 8'h15);
    test_done();
  end
endmodule
